// [design/vector_min_merge_mladd_unit.sv]
// one-stage datapath: vector minimum, multiply-low-add and merge operations
`default_nettype none
//
// Contract
// - signed word minimum on four lanes
// - unsigned byte minimum on sixteen lanes
// - unsigned halfword minimum on eight lanes
// - unsigned word min: a if a<b else b
// - halfword multiply, 32-bit product, add third source
// - keep low 16 bits, no saturation
// - same result for signed and unsigned
// - merge high bytes, a even b odd
// - merge high halfwords, a even b odd
// - merge high words into 0,2 and 1,3
// - merge low bytes, a even b odd
// - merge low halfwords, a even b odd
// - merge low words into 0,2 and 1,3
module vector_min_merge_mladd_unit
    import vec_unit_pkg::*;
(
    input  wire logic        clk,    // core clock
    input  wire logic        rst_n,  // async reset, active low
    input  wire vec_issue_s  issue,  // instruction and source vectors
    output var  vec_result_s result  // registered write-back
);
    // element k (0 = most significant) of width w
    function automatic logic [31:0] elem(input logic [VEC_W-1:0] v, input int w, input int k);
        logic [31:0] r;
        r = '0;
        for (int b = 0; b < w; b++)
            r[b] = v[VEC_W - (k + 1) * w + b];
        return r;
    endfunction : elem

    // merge: half selects high (0) or low (1); a into even, b into odd elements
    function automatic logic [VEC_W-1:0] merge(input logic [VEC_W-1:0] a,
                                               input logic [VEC_W-1:0] b,
                                               input int w, input int half);
        logic [VEC_W-1:0] r;
        int n;
        r = '0;
        n = VEC_W / w;
        for (int k = 0; k < n / 2; k++)
            for (int bt = 0; bt < w; bt++)
            begin
                r[VEC_W - (2 * k + 1) * w + bt] = a[VEC_W - (half * n / 2 + k + 1) * w + bt];
                r[VEC_W - (2 * k + 2) * w + bt] = b[VEC_W - (half * n / 2 + k + 1) * w + bt];
            end
        return r;
    endfunction : merge

    // field extraction on big-endian numbering
    logic [PRIM_W-1:0]    prim;
    logic [XO_VX_W-1:0]   xo_vx;
    logic [XO_VA_W-1:0]   xo_va;
    vec_op_e              op;
    logic [VEC_W-1:0]     a;
    logic [VEC_W-1:0]     b;
    logic [VEC_W-1:0]     c;
    logic [VEC_W-1:0]     min_sw;
    logic [VEC_W-1:0]     min_ub;
    logic [VEC_W-1:0]     min_uh;
    logic [VEC_W-1:0]     min_uw;
    logic [VEC_W-1:0]     mladd;
    vec_result_s          next_result;

    assign prim  = issue.insn[PRIM_LSB +: PRIM_W];
    assign xo_vx = issue.insn[XO_VX_W-1:0];
    assign xo_va = issue.insn[XO_VA_W-1:0];
    assign a     = issue.first_source_vector;
    assign b     = issue.second_source_vector;
    assign c     = issue.third_source_vector;

    // opcode decode; three-source form checked first since its opcode is narrower
    always_comb
    begin
        op = OP_NONE;
        if (prim != PRIM_VEC)
            op = OP_NONE;
        else if (xo_va == XO_MLADD)
            op = OP_MLADD;
        else if (xo_vx == XO_MINSW)
            op = OP_MINSW;
        else if (xo_vx == XO_MINUB)
            op = OP_MINUB;
        else if (xo_vx == XO_MINUH)
            op = OP_MINUH;
        else if (xo_vx == XO_MINUW)
            op = OP_MINUW;
        else if (xo_vx == XO_MRGHB)
            op = OP_MRGHB;
        else if (xo_vx == XO_MRGHH)
            op = OP_MRGHH;
        else if (xo_vx == XO_MRGHW)
            op = OP_MRGHW;
        else if (xo_vx == XO_MRGLB)
            op = OP_MRGLB;
        else if (xo_vx == XO_MRGLH)
            op = OP_MRGLH;
        else if (xo_vx == XO_MRGLW)
            op = OP_MRGLW;
    end

    // lane arithmetic; lanes are position-symmetric so generate indexes from lsb
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_word
            logic [31:0] wa;
            logic [31:0] wb;
            assign wa = a[g*32 +: 32];
            assign wb = b[g*32 +: 32];
            assign min_sw[g*32 +: 32] = ($signed(wa) < $signed(wb)) ? wa : wb;
            assign min_uw[g*32 +: 32] = (wa < wb) ? wa : wb;
        end
        for (g = 0; g < 8; g++)
        begin : g_half
            logic [15:0] ha;
            logic [15:0] hb;
            logic [31:0] prod;
            logic [31:0] sum;
            assign ha = a[g*16 +: 16];
            assign hb = b[g*16 +: 16];
            assign min_uh[g*16 +: 16] = (ha < hb) ? ha : hb;
            // unsigned product; low bits equal the signed ones, so one multiplier
            assign prod = ha * hb;
            assign sum  = prod + {16'h0000, c[g*16 +: 16]};
            assign mladd[g*16 +: 16] = sum[15:0];
        end
        for (g = 0; g < 16; g++)
        begin : g_byte
            logic [7:0] ba;
            logic [7:0] bb;
            assign ba = a[g*8 +: 8];
            assign bb = b[g*8 +: 8];
            assign min_ub[g*8 +: 8] = (ba < bb) ? ba : bb;
        end
    endgenerate

    // result select; also sets the valid and illegal flags and dest_idx, no other status bit
    always_comb
    begin
        next_result          = '0;
        next_result.valid    = issue.valid;
        next_result.illegal  = issue.valid && (op == OP_NONE);
        next_result.dest_idx = issue.insn[DST_LSB +: REG_IDX_W];
        case (op)
            OP_MINSW: next_result.destination_vector = min_sw;
            OP_MINUB: next_result.destination_vector = min_ub;
            OP_MINUH: next_result.destination_vector = min_uh;
            OP_MINUW: next_result.destination_vector = min_uw;
            OP_MLADD: next_result.destination_vector = mladd;
            OP_MRGHB: next_result.destination_vector = merge(a, b, 8, 0);
            OP_MRGHH: next_result.destination_vector = merge(a, b, 16, 0);
            OP_MRGHW: next_result.destination_vector = merge(a, b, 32, 0);
            OP_MRGLB: next_result.destination_vector = merge(a, b, 8, 1);
            OP_MRGLH: next_result.destination_vector = merge(a, b, 16, 1);
            OP_MRGLW: next_result.destination_vector = merge(a, b, 32, 1);
            default:  next_result.destination_vector = '0;
        endcase
    end

    // output register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            result <= '0;
        else
            result <= next_result;
    end
endmodule : vector_min_merge_mladd_unit
`default_nettype wire

// [design/vec_unit_pkg.sv]
// package: opcode fields, operation codes and carrier structs for the vector datapath slice
`default_nettype none
package vec_unit_pkg;
    localparam int VEC_W      = 128;
    localparam int INSN_W     = 32;
    localparam int REG_IDX_W  = 5;
    // big-endian instruction bit positions, expressed as little-endian slice bases
    localparam int PRIM_LSB   = 26;
    localparam int PRIM_W     = 6;
    localparam int DST_LSB    = 21;
    localparam int SRCA_LSB   = 16;
    localparam int SRCB_LSB   = 11;
    localparam int SRCC_LSB   = 6;
    localparam int XO_VX_W    = 11;
    localparam int XO_VA_W    = 6;
    localparam logic [PRIM_W-1:0]  PRIM_VEC = 6'h04;
    localparam logic [XO_VX_W-1:0] XO_MINSW = 11'h382;
    localparam logic [XO_VX_W-1:0] XO_MINUB = 11'h202;
    localparam logic [XO_VX_W-1:0] XO_MINUH = 11'h242;
    localparam logic [XO_VX_W-1:0] XO_MINUW = 11'h282;
    localparam logic [XO_VX_W-1:0] XO_MRGHB = 11'h00c;
    localparam logic [XO_VX_W-1:0] XO_MRGHH = 11'h04c;
    localparam logic [XO_VX_W-1:0] XO_MRGHW = 11'h08c;
    localparam logic [XO_VX_W-1:0] XO_MRGLB = 11'h10c;
    localparam logic [XO_VX_W-1:0] XO_MRGLH = 11'h14c;
    localparam logic [XO_VX_W-1:0] XO_MRGLW = 11'h18c;
    localparam logic [XO_VA_W-1:0] XO_MLADD = 6'h22;

    typedef enum logic [3:0] {
        OP_NONE  = 4'h0,
        OP_MINSW = 4'h1,
        OP_MINUB = 4'h2,
        OP_MINUH = 4'h3,
        OP_MINUW = 4'h4,
        OP_MLADD = 4'h5,
        OP_MRGHB = 4'h6,
        OP_MRGHH = 4'h7,
        OP_MRGHW = 4'h8,
        OP_MRGLB = 4'h9,
        OP_MRGLH = 4'ha,
        OP_MRGLW = 4'hb
    } vec_op_e;

    typedef struct packed {
        logic                 valid;
        logic [INSN_W-1:0]    insn;
        logic [VEC_W-1:0]     first_source_vector;
        logic [VEC_W-1:0]     second_source_vector;
        logic [VEC_W-1:0]     third_source_vector;
    } vec_issue_s;

    typedef struct packed {
        logic                 valid;
        logic                 illegal;
        logic [REG_IDX_W-1:0] dest_idx;
        logic [VEC_W-1:0]     destination_vector;
    } vec_result_s;
endpackage : vec_unit_pkg
`default_nettype wire

// [testbench/issue_source.sv]
// partner: decode side packing an instruction and operands into one issue
`default_nettype none
module issue_source import vec_unit_pkg::*;
(
    input  wire logic         valid, // issue strobe
    input  wire logic [31:0]  insn,  // instruction word
    input  wire logic [127:0] va,    // first operand
    input  wire logic [127:0] vb,    // second operand
    input  wire logic [127:0] vc,    // third operand
    output var  vec_issue_s   issue  // to the slice
);
    timeunit 1ns;
    timeprecision 1ps;
    // operands arrive in the issue cycle, as a register file read would
    assign issue = {valid, insn, va, vb, vc};
endmodule : issue_source
`default_nettype wire

// [testbench/vec_unit_props.sv]
// checker: write-back timing and lane relations of the vector slice
`default_nettype none
module vec_unit_props import vec_unit_pkg::*;
(
    input wire logic        clk,    // core clock
    input wire logic        rst_n,  // async reset, active low
    input wire vec_issue_s  issue,  // issued word and operands
    input wire vec_result_s result  // write-back
);
    timeunit 1ns;
    timeprecision 1ps;
    vec_issue_s p;    // issue one edge back
    logic       live; // low at first edge, so no issue from reset is judged
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            live <= 1'b0;
        else
            live <= 1'b1;
    always_ff @(posedge clk)
        p <= issue;
    wire logic         hit = live && p.valid && p.insn[31:26] == PRIM_VEC;
    wire logic [10:0]  xo  = p.insn[10:0];
    wire logic [127:0] a   = p.first_source_vector;
    wire logic [127:0] b   = p.second_source_vector;
    wire logic [127:0] d   = result.destination_vector;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_VLD: assert property (live |-> result.valid == p.valid)
        else $error("valid lag");
    AST_DST: assert property (hit |-> result.dest_idx == p.insn[25:21])
        else $error("dest index");
    AST_ILL: assert property (live && p.valid && !hit |-> result.illegal && d == '0)
        else $error("illegal");
    AST_MINUW: assert property (hit && xo == XO_MINUW |-> d[127:96] ==
        (a[127:96] < b[127:96] ? a[127:96] : b[127:96])) else $error("minuw");
    AST_MINSW: assert property (hit && xo == XO_MINSW |-> d[31:0] ==
        ($signed(a[31:0]) < $signed(b[31:0]) ? a[31:0] : b[31:0])) else $error("minsw");
    AST_MLADD: assert property (hit && p.insn[5:0] == XO_MLADD |-> d[127:112] ==
        16'(a[127:112] * b[127:112] + p.third_source_vector[127:112])) else $error("mladd");
    AST_MRGHW: assert property (hit && xo == XO_MRGHW |->
        d == {a[127:96], b[127:96], a[95:64], b[95:64]}) else $error("mrghw");
    AST_MRGLW: assert property (hit && xo == XO_MRGLW |->
        d == {a[63:32], b[63:32], a[31:0], b[31:0]}) else $error("mrglw");
endmodule : vec_unit_props
bind vector_min_merge_mladd_unit vec_unit_props u_vec_unit_props (.clk(clk),
    .rst_n(rst_n), .issue(issue), .result(result));
`default_nettype wire

// [testbench/testbench.sv]
// bench: every operation of the vector slice, back to back
`default_nettype none
module testbench import vec_unit_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk, rst_n, vld;
    logic [31:0]  insn;
    logic [127:0] a, b, c;
    vec_issue_s   issue;
    vec_result_s  result;
    int           bad_count, n_compared;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %0t %h %h", $time, g, e); end end
    issue_source u_issue_source (.valid(vld), .insn(insn), .va(a), .vb(b), .vc(c),
        .issue(issue));
    vector_min_merge_mladd_unit u_vector_min_merge_mladd_unit (.clk(clk), .rst_n(rst_n),
        .issue(issue), .result(result));
    // expected lane minimum; signed compare by flipping the top bit
    function automatic logic [127:0] mn(input logic [127:0] x, y, input int w, input bit s);
        logic [127:0] m, t, p, q, r;
        m = (128'h1 << w) - 128'h1;
        t = 128'(s) << (w - 1);
        r = '0;
        for (int i = 0; i < 128; i += w)
        begin
            p = (x >> i) & m;
            q = (y >> i) & m;
            r |= (((p ^ t) < (q ^ t)) ? p : q) << i;
        end
        return r;
    endfunction : mn
    // expected merge; element zero sits at the top
    function automatic logic [127:0] mg(input logic [127:0] x, y, input int w, input bit h);
        logic [127:0] m, r, u, v;
        m = (128'h1 << w) - 128'h1;
        u = h ? x >> 64 : x & {64'h0, {64{1'b1}}};
        v = h ? y >> 64 : y & {64'h0, {64{1'b1}}};
        r = '0;
        for (int k = 0; k < 64 / w; k++)
        begin
            r |= ((u >> (64 - w * (k + 1))) & m) << (128 - w * (2 * k + 1));
            r |= ((v >> (64 - w * (k + 1))) & m) << (128 - w * (2 * k + 2));
        end
        return r;
    endfunction : mg
    // drive one issue, check the write-back one edge later
    task automatic go(input logic [31:0] i, input logic [127:0] e);
        logic [127:0] r;
        for (int k = 0; k < 128; k += 16)
            r[k+:16] = 16'(a[k+:16] * b[k+:16] + c[k+:16]);
        insn = i;
        vld = 1'b1;
        @(posedge clk);
        #1;
        `CHK({result.valid, result.illegal, result.dest_idx}, {1'b1, i[31:26] != 6'h04, i[25:21]})
        `CHK(result.destination_vector, (i[5:0] == 6'h22) ? r : e)
    endtask : go
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // about 20 cycles of work; far beyond that means a hang
    initial
    begin
        #2000;
        bad_count++;
        complete_run();
    end
    initial
    begin
        {rst_n, vld, insn} = '0;
        a = 128'h80ff7f01_00000005_fffffffe_12345678;
        b = 128'h7f01ff80_00000005_00000001_87654321;
        c = 128'hffff0001_80007fff_00001234_fffe0002;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        go(32'h11e00382, mn(a, b, 32, 1));
        go(32'h10000202, mn(a, b, 8, 0));
        go(32'h10200242, mn(a, b, 16, 0));
        go(32'h13e00282, mn(a, b, 32, 0));
        $display("min test done");
        go(32'h10a007e2, '0);
        $display("mladd test done");
        go(32'h1000000c, mg(a, b, 8, 1));
        go(32'h1000004c, mg(a, b, 16, 1));
        go(32'h1000008c, mg(a, b, 32, 1));
        go(32'h1000010c, mg(a, b, 8, 0));
        go(32'h1000014c, mg(a, b, 16, 0));
        go(32'h1000018c, mg(a, b, 32, 0));
        $display("merge test done");
        go(32'h14000202, '0);
        // right primary opcode, unknown extended opcode: still illegal, zero vector
        insn = 32'h10200001;
        @(posedge clk);
        #1;
        `CHK({result.valid, result.illegal, result.dest_idx}, {1'b1, 1'b1, 5'h01})
        `CHK(result.destination_vector, 128'h0)
        vld = 1'b0;
        @(posedge clk);
        #1;
        `CHK(result.valid, 1'b0)
        $display("illegal test done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
